/* File: hdl/tx_gain_offset_control_regs.v */
// transmit trim register bank: dc offset, coarse and fine gain, shared gain amplifier code
`timescale 1ns/1ps
`include "tx_gain_offset_control_regs.vh"

module tx_gain_offset_control_regs (
  // clock and reset
  input  wire       clock,
  input  wire       sys_rst,
  // register access from the serial configuration port
  input  wire       cfg_wr_strobe,
  input  wire       cfg_rd_strobe,
  input  wire [7:0] cfg_addr,
  input  wire [7:0] cfg_wr_data,
  output reg  [7:0] cfg_rd_data,
  output reg        cfg_rd_valid,
  // transmit power-down pin
  input  wire       tx_powerdown_pin,
  // channel a controls
  output wire [1:0] chan_a_coarse_scale,
  output wire       chan_a_fine_up,
  output wire [5:0] chan_a_fine_mag,
  output wire       chan_a_offset_add,
  output wire [8:0] chan_a_offset_mag,
  output wire       chan_a_offset_pos_en,
  output wire       chan_a_offset_neg_en,
  // channel b controls
  output wire [1:0] chan_b_coarse_scale,
  output wire       chan_b_fine_up,
  output wire [5:0] chan_b_fine_mag,
  output wire       chan_b_offset_add,
  output wire [8:0] chan_b_offset_mag,
  output wire       chan_b_offset_pos_en,
  output wire       chan_b_offset_neg_en,
  // shared gain amplifier controls
  output reg  [7:0] tx_gain_amp_code,
  output reg        tx_gain_amp_fast,
  output reg        tx_gain_amp_pending
);

  // stored register contents
  reg  [9:0] chan_a_offset_reg;
  reg  [9:0] chan_a_offset_next;
  reg        chan_a_dir_reg;
  reg        chan_a_dir_next;
  reg  [9:0] chan_b_offset_reg;
  reg  [9:0] chan_b_offset_next;
  reg        chan_b_dir_reg;
  reg        chan_b_dir_next;
  reg  [7:0] chan_a_gain_trim_reg;
  reg  [7:0] chan_a_gain_trim_next;
  reg  [7:0] chan_b_gain_trim_reg;
  reg  [7:0] chan_b_gain_trim_next;
  reg  [7:0] shared_amp_gain_code_reg;
  reg  [7:0] shared_amp_gain_code_next;
  reg  [7:0] amp_update_control_reg;
  reg  [7:0] amp_update_control_next;

  // amplifier update tracking
  reg  [7:0] amp_applied_next;
  reg        amp_pending_next;
  reg        pin_level_prev_reg;
  reg        amp_wr_seen_reg;
  reg  [7:0] rd_data_next;

  wire       pin_level;
  wire       pin_fall;
  wire       slave_en;
  wire       wr_amp_code;
  wire       wr_amp_ctrl;

  // clean copy of the power-down pin
  pin_sync3 u_pin_sync (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .pin_in    (tx_powerdown_pin),
    .level_out (pin_level)
  );

  // falling edge seen only on the filtered level, never on raw stages
  always @(posedge clock) begin
    if (sys_rst) begin
      pin_level_prev_reg <= 1'b0;
    end else begin
      pin_level_prev_reg <= pin_level;
    end
  end

  assign pin_fall    = pin_level_prev_reg & ~pin_level;
  assign slave_en    = amp_update_control_reg[`AMP_SLAVE_EN_BIT];
  assign wr_amp_code = cfg_wr_strobe && (cfg_addr == `OFS_AMP_GAIN_CODE);
  assign wr_amp_ctrl = cfg_wr_strobe && (cfg_addr == `OFS_AMP_UPDATE_CTRL);

  // register write decode; one byte per access
  always @* begin
    chan_a_offset_next        = chan_a_offset_reg;
    chan_a_dir_next           = chan_a_dir_reg;
    chan_b_offset_next        = chan_b_offset_reg;
    chan_b_dir_next           = chan_b_dir_reg;
    chan_a_gain_trim_next     = chan_a_gain_trim_reg;
    chan_b_gain_trim_next     = chan_b_gain_trim_reg;
    shared_amp_gain_code_next = shared_amp_gain_code_reg;
    amp_update_control_next   = amp_update_control_reg;
    if (!cfg_wr_strobe) begin
      chan_a_offset_next = chan_a_offset_reg;
    end else if (cfg_addr == `OFS_CHAN_A_OFFSET_HI) begin
      chan_a_offset_next[9:8] = cfg_wr_data[`OFFSET_HI_MSB:0];
      chan_a_dir_next         = cfg_wr_data[`OFFSET_DIR_BIT];
    end else if (cfg_addr == `OFS_CHAN_A_OFFSET_LO) begin
      chan_a_offset_next[7:0] = cfg_wr_data;
    end else if (cfg_addr == `OFS_CHAN_A_GAIN_TRIM) begin
      chan_a_gain_trim_next = cfg_wr_data;
    end else if (cfg_addr == `OFS_CHAN_B_OFFSET_HI) begin
      chan_b_offset_next[9:8] = cfg_wr_data[`OFFSET_HI_MSB:0];
      chan_b_dir_next         = cfg_wr_data[`OFFSET_DIR_BIT];
    end else if (cfg_addr == `OFS_CHAN_B_OFFSET_LO) begin
      chan_b_offset_next[7:0] = cfg_wr_data;
    end else if (cfg_addr == `OFS_CHAN_B_GAIN_TRIM) begin
      chan_b_gain_trim_next = cfg_wr_data;
    end else if (cfg_addr == `OFS_AMP_GAIN_CODE) begin
      shared_amp_gain_code_next = cfg_wr_data;
    end else if (cfg_addr == `OFS_AMP_UPDATE_CTRL) begin
      amp_update_control_next = cfg_wr_data;
    end
  end

  // which code drives the amplifier, and whether one waits for wake-up
  always @* begin
    amp_applied_next = tx_gain_amp_code;
    amp_pending_next = tx_gain_amp_pending;
    if (!slave_en) begin
      // immediate mode: the byte lands at the write edge, so load one cycle later
      if (amp_wr_seen_reg || tx_gain_amp_pending) begin
        amp_applied_next = shared_amp_gain_code_reg;
        amp_pending_next = 1'b0;
      end
    end else if (pin_fall) begin
      // wake-up edge commits whatever is stored, even with nothing pending
      amp_applied_next = shared_amp_gain_code_reg;
      amp_pending_next = 1'b0;
    end
    // a write in the edge cycle is newer than the code just loaded
    if (slave_en && wr_amp_code) begin
      amp_pending_next = 1'b1;
    end
  end

  // register state; offsets start at zero so no current flows
  always @(posedge clock) begin
    if (sys_rst) begin
      chan_a_offset_reg        <= `RST_OFFSET;
      chan_a_dir_reg           <= `RST_OFFSET_DIR;
      chan_b_offset_reg        <= `RST_OFFSET;
      chan_b_dir_reg           <= `RST_OFFSET_DIR;
      chan_a_gain_trim_reg     <= `RST_GAIN_TRIM;
      chan_b_gain_trim_reg     <= `RST_GAIN_TRIM;
      shared_amp_gain_code_reg <= `RST_AMP_GAIN_CODE;
      amp_update_control_reg   <= `RST_AMP_UPDATE_CTRL;
    end else begin
      chan_a_offset_reg        <= chan_a_offset_next;
      chan_a_dir_reg           <= chan_a_dir_next;
      chan_b_offset_reg        <= chan_b_offset_next;
      chan_b_dir_reg           <= chan_b_dir_next;
      chan_a_gain_trim_reg     <= chan_a_gain_trim_next;
      chan_b_gain_trim_reg     <= chan_b_gain_trim_next;
      shared_amp_gain_code_reg <= shared_amp_gain_code_next;
      amp_update_control_reg   <= amp_update_control_next;
    end
  end

  // applied amplifier code is straight binary; 0x00 is -20 dB, 0xff is 0 dB
  always @(posedge clock) begin
    if (sys_rst) begin
      tx_gain_amp_code    <= `RST_AMP_GAIN_CODE;
      tx_gain_amp_pending <= 1'b0;
      tx_gain_amp_fast    <= 1'b0;
      amp_wr_seen_reg     <= 1'b0;
    end else begin
      amp_wr_seen_reg     <= wr_amp_code;
      tx_gain_amp_code    <= amp_applied_next;
      tx_gain_amp_pending <= amp_pending_next;
      tx_gain_amp_fast    <= amp_update_control_next[`AMP_FAST_BIT];
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    rd_data_next = 8'h00;
    if (cfg_addr == `OFS_CHAN_A_OFFSET_HI) begin
      rd_data_next = {chan_a_dir_reg, 5'h00, chan_a_offset_reg[9:8]};
    end else if (cfg_addr == `OFS_CHAN_A_OFFSET_LO) begin
      rd_data_next = chan_a_offset_reg[7:0];
    end else if (cfg_addr == `OFS_CHAN_A_GAIN_TRIM) begin
      rd_data_next = chan_a_gain_trim_reg;
    end else if (cfg_addr == `OFS_CHAN_B_OFFSET_HI) begin
      rd_data_next = {chan_b_dir_reg, 5'h00, chan_b_offset_reg[9:8]};
    end else if (cfg_addr == `OFS_CHAN_B_OFFSET_LO) begin
      rd_data_next = chan_b_offset_reg[7:0];
    end else if (cfg_addr == `OFS_CHAN_B_GAIN_TRIM) begin
      rd_data_next = chan_b_gain_trim_reg;
    end else if (cfg_addr == `OFS_AMP_GAIN_CODE) begin
      rd_data_next = shared_amp_gain_code_reg;
    end else if (cfg_addr == `OFS_AMP_UPDATE_CTRL) begin
      rd_data_next = amp_update_control_reg;
    end else if (cfg_addr == `OFS_AMP_STATUS) begin
      rd_data_next[`STAT_PENDING_BIT]   = tx_gain_amp_pending;
      rd_data_next[`STAT_PIN_LEVEL_BIT] = pin_level;
    end
  end

  // read answer one cycle after the strobe, held until the next read
  always @(posedge clock) begin
    if (sys_rst) begin
      cfg_rd_data  <= 8'h00;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd_strobe;
      if (cfg_rd_strobe) begin
        cfg_rd_data <= rd_data_next;
      end
    end
  end

  // channel a decode
  chan_trim_decode u_chan_a (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .gain_trim     (chan_a_gain_trim_reg),
    .offset_ctrl   (chan_a_offset_reg),
    .offset_dir    (chan_a_dir_reg),
    .coarse_scale  (chan_a_coarse_scale),
    .fine_up       (chan_a_fine_up),
    .fine_mag      (chan_a_fine_mag),
    .offset_add    (chan_a_offset_add),
    .offset_mag    (chan_a_offset_mag),
    .offset_pos_en (chan_a_offset_pos_en),
    .offset_neg_en (chan_a_offset_neg_en)
  );

  // channel b decode
  chan_trim_decode u_chan_b (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .gain_trim     (chan_b_gain_trim_reg),
    .offset_ctrl   (chan_b_offset_reg),
    .offset_dir    (chan_b_dir_reg),
    .coarse_scale  (chan_b_coarse_scale),
    .fine_up       (chan_b_fine_up),
    .fine_mag      (chan_b_fine_mag),
    .offset_add    (chan_b_offset_add),
    .offset_mag    (chan_b_offset_mag),
    .offset_pos_en (chan_b_offset_pos_en),
    .offset_neg_en (chan_b_offset_neg_en)
  );

endmodule // tx_gain_offset_control_regs

/* File: pkg/tx_gain_offset_control_regs.vh */
// register offsets, field positions, reset values and timing for the transmit trim bank
`ifndef TX_GAIN_OFFSET_CONTROL_REGS_VH
`define TX_GAIN_OFFSET_CONTROL_REGS_VH

// register offsets on the configuration port
`define OFS_CHAN_A_OFFSET_HI   8'h0b
`define OFS_CHAN_A_OFFSET_LO   8'h0c
`define OFS_CHAN_A_GAIN_TRIM   8'h0d
`define OFS_CHAN_B_OFFSET_HI   8'h0e
`define OFS_CHAN_B_OFFSET_LO   8'h0f
`define OFS_CHAN_B_GAIN_TRIM   8'h10
`define OFS_AMP_GAIN_CODE      8'h11
`define OFS_AMP_UPDATE_CTRL    8'h12
`define OFS_AMP_STATUS         8'h1f

// offset high byte and offset word fields
`define OFFSET_DIR_BIT         7
`define OFFSET_HI_MSB          1
`define OFFSET_WIDTH           10
`define OFFSET_SIGN_BIT        9
`define OFFSET_MAG_MSB         8

// gain trim fields
`define COARSE_MSB             7
`define COARSE_LSB             6
`define FINE_MSB               5
`define FINE_WIDTH             6

// update control fields
`define AMP_SLAVE_EN_BIT       6
`define AMP_FAST_BIT           4

// status fields
`define STAT_PENDING_BIT       0
`define STAT_PIN_LEVEL_BIT     1

// coarse scaling selections
`define COARSE_DIV11           2'h0
`define COARSE_HALF            2'h1
`define COARSE_FULL            2'h2

// reset values
`define RST_OFFSET             10'h000
`define RST_OFFSET_DIR         1'b0
`define RST_GAIN_TRIM          8'h80
`define RST_AMP_GAIN_CODE      8'hff
`define RST_AMP_UPDATE_CTRL    8'h00

// pin synchroniser depth
`define SYNC_STAGES            3

`endif

/* File: hdl/pin_sync3.v */
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps

module pin_sync3 (
  // clock and reset
  input  wire clock,
  input  wire sys_rst,
  // asynchronous pin and its clean level
  input  wire pin_in,
  output reg  level_out
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // only s2 reads s1, so a metastable first stage never feeds logic
  always @(posedge clock) begin
    if (sys_rst) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a change counts only when two late stages agree
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end

endmodule // pin_sync3

/* File: hdl/chan_trim_decode.v */
// per-channel decode of coarse gain, fine gain trim and dc offset into registered controls
`timescale 1ns/1ps
`include "tx_gain_offset_control_regs.vh"

module chan_trim_decode (
  // clock and reset
  input  wire       clock,
  input  wire       sys_rst,
  // raw register contents
  input  wire [7:0] gain_trim,
  input  wire [9:0] offset_ctrl,
  input  wire       offset_dir,
  // decoded controls
  output reg  [1:0] coarse_scale,
  output reg        fine_up,
  output reg  [5:0] fine_mag,
  output reg        offset_add,
  output reg  [8:0] offset_mag,
  output reg        offset_pos_en,
  output reg        offset_neg_en
);

  wire [5:0] fine_code;
  wire       offset_live;

  assign fine_code   = gain_trim[`FINE_MSB:0];
  assign offset_live = |offset_ctrl[`OFFSET_MAG_MSB:0];

  // registered decode keeps the analog controls glitch free
  always @(posedge clock) begin
    if (sys_rst) begin
      coarse_scale  <= `COARSE_FULL;
      fine_up       <= 1'b0;
      fine_mag      <= 6'h00;
      offset_add    <= 1'b0;
      offset_mag    <= 9'h000;
      offset_pos_en <= 1'b0;
      offset_neg_en <= 1'b0;
    end else begin
      // 00 one eleventh, 01 half, 1x unscaled
      case (gain_trim[`COARSE_MSB:`COARSE_LSB])
        2'h0:    coarse_scale <= `COARSE_DIV11;
        2'h1:    coarse_scale <= `COARSE_HALF;
        default: coarse_scale <= `COARSE_FULL;
      endcase
      // negative codes raise gain; 100000 is the largest step
      fine_up <= fine_code[5];
      if (fine_code[5]) begin
        fine_mag <= 6'h00 - fine_code;
      end else begin
        fine_mag <= fine_code;
      end
      offset_add    <= offset_ctrl[`OFFSET_SIGN_BIT];
      offset_mag    <= offset_ctrl[`OFFSET_MAG_MSB:0];
      offset_pos_en <= offset_live & offset_dir;
      offset_neg_en <= offset_live & ~offset_dir;
    end
  end

endmodule // chan_trim_decode

/* File: verif/tx_gain_offset_control_regs_props.sv */
// assertion checker for the transmit trim register bank
`timescale 1ns/1ps
`include "tx_gain_offset_control_regs.vh"

module tx_gain_offset_control_regs_props (
  // clock and reset
  input wire       clock,
  input wire       sys_rst,
  // register port
  input wire       cfg_wr_strobe,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wr_data,
  // pin and decoded controls
  input wire       tx_powerdown_pin,
  input wire [1:0] chan_a_coarse_scale,
  input wire       chan_a_fine_up,
  input wire [5:0] chan_a_fine_mag,
  input wire [8:0] chan_a_offset_mag,
  input wire       chan_a_offset_pos_en,
  input wire       chan_a_offset_neg_en,
  input wire [8:0] chan_b_offset_mag,
  input wire [7:0] tx_gain_amp_code,
  input wire       tx_gain_amp_pending
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // write decodes seen at the port
  wire gain_wr = cfg_wr_strobe && cfg_addr == `OFS_CHAN_A_GAIN_TRIM;
  wire amp_wr  = cfg_wr_strobe && cfg_addr == `OFS_AMP_GAIN_CODE;

  // shadow slave bit; the port alone cannot tell deferred from immediate
  reg slave_q;
  always @(posedge clock) begin
    if (sys_rst)
      slave_q <= 1'b0;
    else if (cfg_wr_strobe && cfg_addr == `OFS_AMP_UPDATE_CTRL)
      slave_q <= cfg_wr_data[`AMP_SLAVE_EN_BIT];
  end

  // pin falls in slave mode and then stays low with the port quiet
  sequence wake_held;
    $fell(tx_powerdown_pin) && slave_q && tx_gain_amp_pending && !cfg_wr_strobe
      ##1 (!tx_powerdown_pin && !cfg_wr_strobe)[*7];
  endsequence

  chk_enable_needs_mag: assert property ((chan_a_offset_pos_en || chan_a_offset_neg_en) |-> chan_a_offset_mag != 9'h000)
    else $error("offset pin enabled with zero magnitude");
  chk_one_pin_only: assert property (!(chan_a_offset_pos_en && chan_a_offset_neg_en))
    else $error("offset applied to both pins");
  chk_coarse_fine_bits: assert property (gain_wr |-> ##2 chan_a_fine_up == $past(cfg_wr_data[5], 2)
    && chan_a_coarse_scale == ($past(cfg_wr_data[7], 2) ? 2'h2 : {1'b0, $past(cfg_wr_data[6], 2)}))
    else $error("gain trim decode wrong");
  chk_fine_magnitude: assert property (gain_wr |-> ##2 chan_a_fine_mag ==
    ($past(cfg_wr_data[5], 2) ? 6'h00 - $past(cfg_wr_data[5:0], 2) : $past(cfg_wr_data[5:0], 2)))
    else $error("fine trim magnitude wrong");
  chk_amp_reset_max: assert property ($past(sys_rst) |-> tx_gain_amp_code == `RST_AMP_GAIN_CODE && !tx_gain_amp_pending)
    else $error("amplifier code not at maximum after reset");
  chk_offset_reset_zero: assert property ($past(sys_rst) |-> chan_a_offset_mag == 9'h000 && chan_b_offset_mag == 9'h000)
    else $error("offset not zero after reset");
  chk_amp_immediate: assert property (amp_wr && !slave_q |-> ##2 tx_gain_amp_code == $past(cfg_wr_data, 2))
    else $error("amplifier code not applied after write");
  chk_slave_holds: assert property ((slave_q && tx_powerdown_pin && !cfg_wr_strobe)[*8] |=> $stable(tx_gain_amp_code))
    else $error("amplifier code moved without wake-up edge");
  chk_wake_load: assert property (wake_held |-> !tx_gain_amp_pending)
    else $error("deferred code not loaded after wake-up");

  cov_immediate: cover property (amp_wr && !slave_q);
  cov_wake: cover property (wake_held);
  cov_gain_write: cover property (gain_wr);
endmodule // tx_gain_offset_control_regs_props

bind tx_gain_offset_control_regs tx_gain_offset_control_regs_props props_inst (
  .clock(clock), .sys_rst(sys_rst), .cfg_wr_strobe(cfg_wr_strobe), .cfg_addr(cfg_addr),
  .cfg_wr_data(cfg_wr_data), .tx_powerdown_pin(tx_powerdown_pin), .chan_a_coarse_scale(chan_a_coarse_scale),
  .chan_a_fine_up(chan_a_fine_up), .chan_a_fine_mag(chan_a_fine_mag), .chan_a_offset_mag(chan_a_offset_mag),
  .chan_a_offset_pos_en(chan_a_offset_pos_en), .chan_a_offset_neg_en(chan_a_offset_neg_en),
  .chan_b_offset_mag(chan_b_offset_mag), .tx_gain_amp_code(tx_gain_amp_code),
  .tx_gain_amp_pending(tx_gain_amp_pending));

/* File: verif/tx_gain_offset_control_regs_test.sv */
// self-checking bench for the transmit trim register bank
`timescale 1ns/1ps
`include "tx_gain_offset_control_regs.vh"

module tx_gain_offset_control_regs_test;
  // fine trim codes and their expected {raise, magnitude}
  localparam [29:0] FINE_CODES = {6'h1f, 6'h01, 6'h00, 6'h3f, 6'h20};
  localparam [34:0] FINE_EXP   = {7'h1f, 7'h01, 7'h00, 7'h41, 7'h60};
  reg        clock, sys_rst, cfg_wr_strobe, cfg_rd_strobe, tx_powerdown_pin;
  reg  [7:0] cfg_addr, cfg_wr_data;
  wire [7:0] cfg_rd_data, amp_code;
  wire       cfg_rd_valid, amp_fast, amp_pending;
  wire [1:0] coarse [2];
  wire [5:0] fmag   [2];
  wire [8:0] omag   [2];
  wire       up [2], add [2], pos [2], neg [2];
  integer    errors = 0, check_count = 0, cycles = 0, ch, i;

  tx_gain_offset_control_regs dut (
    .clock(clock), .sys_rst(sys_rst), .cfg_wr_strobe(cfg_wr_strobe), .cfg_rd_strobe(cfg_rd_strobe),
    .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid),
    .tx_powerdown_pin(tx_powerdown_pin), .chan_a_coarse_scale(coarse[0]), .chan_a_fine_up(up[0]),
    .chan_a_fine_mag(fmag[0]), .chan_a_offset_add(add[0]), .chan_a_offset_mag(omag[0]),
    .chan_a_offset_pos_en(pos[0]), .chan_a_offset_neg_en(neg[0]), .chan_b_coarse_scale(coarse[1]),
    .chan_b_fine_up(up[1]), .chan_b_fine_mag(fmag[1]), .chan_b_offset_add(add[1]), .chan_b_offset_mag(omag[1]),
    .chan_b_offset_pos_en(pos[1]), .chan_b_offset_neg_en(neg[1]), .tx_gain_amp_code(amp_code),
    .tx_gain_amp_fast(amp_fast), .tx_gain_amp_pending(amp_pending));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
    end
  endtask

  // one-cycle write strobe, taken at the second edge
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      cfg_wr_strobe <= 1'b1;
      cfg_addr <= a;
      cfg_wr_data <= d;
      @(posedge clock);
      cfg_wr_strobe <= 1'b0;
    end
  endtask

  // read valid stands only in the cycle after the edge that takes the strobe; the data holds until the next read
  task rd_chk(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clock);
      cfg_rd_strobe <= 1'b1;
      cfg_addr <= a;
      @(posedge clock);
      cfg_rd_strobe <= 1'b0;
      #1;
      check(cfg_rd_valid, 1'b1);
      check(cfg_rd_data, exp);
    end
  endtask

  // settle past registered outputs
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask

  task summarize;
    begin
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // hang guard, well above the roughly 140 cycles the run needs
  initial begin
    forever begin
      @(posedge clock);
      cycles = cycles + 1;
      if (cycles == 3000) begin
        errors = errors + 1;
        summarize();
      end
    end
  end

  initial begin
    sys_rst = 1'b1;
    cfg_wr_strobe = 1'b0;
    cfg_rd_strobe = 1'b0;
    cfg_addr = 8'h00;
    cfg_wr_data = 8'h00;
    tx_powerdown_pin = 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    tick(1);
    check(amp_code, `RST_AMP_GAIN_CODE);
    check({omag[0], omag[1], pos[0], neg[0], pos[1], neg[1]}, 32'h0);
    check({coarse[0], up[0], fmag[0]}, {2'h2, 7'h00});
    rd_chk(`OFS_AMP_GAIN_CODE, 8'hff);
    rd_chk(`OFS_CHAN_A_OFFSET_LO, 8'h00);
    rd_chk(8'h30, 8'h00);
    // every coarse code and the fine trim corners on both channels
    for (ch = 0; ch < 2; ch = ch + 1) begin
      for (i = 0; i < 5; i = i + 1) begin
        wr(ch ? `OFS_CHAN_B_GAIN_TRIM : `OFS_CHAN_A_GAIN_TRIM, {i[1:0], FINE_CODES[i*6 +: 6]});
        tick(2);
        check(coarse[ch], i[1] ? 2'h2 : i[1:0]);
        check({up[ch], fmag[ch]}, FINE_EXP[i*7 +: 7]);
      end
    end
    check({coarse[0], up[0], fmag[0]}, {2'h0, 7'h1f});
    rd_chk(`OFS_CHAN_B_GAIN_TRIM, 8'h1f);
    // offsets: add to positive pin on a, subtract on negative pin of b
    wr(`OFS_CHAN_A_OFFSET_HI, 8'h83);
    wr(`OFS_CHAN_A_OFFSET_LO, 8'h05);
    wr(`OFS_CHAN_B_OFFSET_HI, 8'h01);
    wr(`OFS_CHAN_B_OFFSET_LO, 8'h00);
    tick(2);
    check({add[0], omag[0], pos[0], neg[0]}, {1'b1, 9'h105, 2'b10});
    check({add[1], omag[1], pos[1], neg[1]}, {1'b0, 9'h100, 2'b01});
    rd_chk(`OFS_CHAN_A_OFFSET_HI, 8'h83);
    wr(`OFS_CHAN_A_OFFSET_LO, 8'h00);
    wr(`OFS_CHAN_A_OFFSET_HI, 8'h82);
    tick(2);
    check({add[0], omag[0], pos[0], neg[0]}, {1'b1, 9'h000, 2'b00});
    // immediate amplifier update to minimum gain
    wr(`OFS_AMP_GAIN_CODE, 8'h00);
    tick(2);
    check(amp_code, 8'h00);
    // deferred update waits for the wake-up edge
    wr(`OFS_AMP_UPDATE_CTRL, 8'h40);
    wr(`OFS_AMP_GAIN_CODE, 8'h5a);
    tick(12);
    check({amp_pending, amp_code}, {1'b1, 8'h00});
    rd_chk(`OFS_AMP_STATUS, 8'h03);
    @(posedge clock);
    tx_powerdown_pin <= 1'b0;
    tick(10);
    check({amp_pending, amp_code}, {1'b0, 8'h5a});
    @(posedge clock);
    tx_powerdown_pin <= 1'b1;
    tick(10);
    // leaving slave mode while a code waits releases it
    wr(`OFS_AMP_GAIN_CODE, 8'hc3);
    wr(`OFS_AMP_UPDATE_CTRL, 8'h10);
    tick(3);
    check({amp_fast, amp_pending, amp_code}, {2'b10, 8'hc3});
    wr(`OFS_AMP_STATUS, 8'h00);
    rd_chk(`OFS_AMP_STATUS, 8'h02);
    wr(8'h30, 8'h55);
    rd_chk(8'h30, 8'h00);
    wr(`OFS_AMP_GAIN_CODE, 8'h7e);
    // second reset in mid-run
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    tick(1);
    check({amp_fast, amp_pending, amp_code}, {2'b00, `RST_AMP_GAIN_CODE});
    check({omag[0], omag[1]}, 18'h0);
    rd_chk(`OFS_CHAN_A_GAIN_TRIM, `RST_GAIN_TRIM);
    summarize();
  end
endmodule // tx_gain_offset_control_regs_test
